// [shared/rlm_pkg.sv]
// Constants, types and carriers shared by the ribbon life monitor design
// Behaviour
// R1 - Show remaining life percent, 100 down to 0
// R2 - Warn and flash lamp at 2 percent
// R3 - Halt printing at 0 under halt policy
// R4 - Keep buffered print data while ink end holds
// R5 - Fresh cartridge: clear on platen close, 100 percent
// R6 - Used cartridge resumes from its stored count
// R7 - Count dots, rewrite count to cartridge periodically
// R8 - Read length, colour, yield; detect new or used
// R9 - One global density setting, default Normal
// R10 - Arrows step +6 to -10, Enter commits
// R11 - Keep density offset, use new type's count
// R12 - Recompute end point immediately on change
// R13 - Ink out: message, lamp, alarm, halt, fault
// R14 - Clear key grants two more minutes, repeatably
// R15 - Depleted cartridge at power up: fault
// R16 - Run-past policy: show 0, keep printing quietly
// R17 - Run-past absolute end: halt, lamp, alarm, wear fault
// R18 - Wear fault ignores key, clears on platen open
// R19 - Reused cartridge accepted unless declared ink out
// R20 - Percent from dots against density-adjusted count
// R21 - Alarm gated by configuration enable
`default_nettype none
package rlm_pkg;

    // ********
    // Timing
    // ********
    localparam longint RLM_CLK_HZ = 64'd100_000_000;
    localparam longint RLM_GRACE_S = 64'd120;
    localparam longint RLM_FLASH_MS = 64'd250;
    localparam int RLM_TMR_W = 36;
    localparam logic [35:0] RLM_GRACE_CYCLES = 36'(RLM_GRACE_S * RLM_CLK_HZ);
    localparam logic [35:0] RLM_FLASH_CYCLES = 36'(RLM_FLASH_MS * RLM_CLK_HZ / 64'd1000);

    // ********
    // Life figures and density steps
    // ********
    localparam logic [6:0] RLM_FULL_PCT = 7'h64;
    localparam logic [6:0] RLM_LOW_PCT = 7'h02;
    localparam logic signed [4:0] RLM_DARK_MAX = 5'sh06;
    localparam logic signed [4:0] RLM_LIGHT_MIN = -5'sh0a;
    localparam logic signed [4:0] RLM_STEP_NORMAL = 5'sh00;
    localparam int RLM_STEP_SHIFT = 5;
    localparam logic [11:0] RLM_WB_DOTS = 12'hfff;
    localparam logic [5:0] RLM_DIV_STEPS = 6'h28;

    // ********
    // Carriers
    // ********
    typedef struct packed {
        logic load;
        logic is_new;
        logic authorized;
        logic ink_out_mark;
        logic [31:0] used_dots;
        logic [31:0] eol_dots;
        logic [31:0] abs_eol_dots;
        logic [15:0] length;
        logic [3:0] colour;
        logic [31:0] yield;
    } rlm_cart_t;

    typedef struct packed {
        logic [15:0] length;
        logic [3:0] colour;
        logic [31:0] yield;
        logic is_new;
    } rlm_info_t;

    typedef struct packed {
        logic strobe;
        logic ink_out;
        logic [31:0] dots;
    } rlm_wb_t;

    typedef struct packed {
        logic left;
        logic right;
        logic enter;
        logic key_a;
    } rlm_keys_t;

    typedef enum logic [2:0] {
        ST_EMPTY, ST_RUN, ST_INK_OUT, ST_GRACE, ST_OLD, ST_WEAR
    } rlm_state_t;

    typedef enum logic [2:0] {
        MSG_NONE, MSG_LOW, MSG_INK_OUT, MSG_GRACE, MSG_OLD, MSG_WEAR
    } rlm_msg_t;

endpackage
`default_nettype wire

// [rtl/rlm_timer.sv]
// One-shot cycle timer with a registered done pulse
`timescale 1ns/100ps
`default_nettype none
module rlm_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire logic [35:0] period,
    // Status
    output var logic running,
    output var logic done
);
    import rlm_pkg::*;

    logic [35:0] cnt_q, cnt_d;
    logic run_d, done_d;

    // Load restarts a run; the last count raises done for one cycle
    always_comb begin
        cnt_d = cnt_q;
        run_d = running;
        done_d = 1'b0;
        if (load) begin
            cnt_d = period;
            run_d = 1'b1;
        end else if (running) begin
            if (cnt_q <= 36'h1) begin
                run_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 36'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 36'h0;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            running <= run_d;
            done <= done_d;
        end
    end
endmodule // rlm_timer
`default_nettype wire

// [rtl/rlm_pct_div.sv]
// Restoring divider for the consumed-life ratio
`timescale 1ns/100ps
`default_nettype none
module rlm_pct_div (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Operands
    input wire logic start,
    input wire logic [39:0] num,
    input wire logic [35:0] den,
    // Result
    output var logic busy,
    output var logic done,
    output var logic [39:0] quot
);
    import rlm_pkg::*;

    logic [36:0] rem_q, rem_d, trial;
    logic [39:0] q_q, q_d, quot_d;
    logic [35:0] den_q, den_d;
    logic [5:0] cnt_q, cnt_d;
    logic busy_d, done_d;

    // One quotient bit per cycle; quotient shifts in where numerator leaves
    always_comb begin
        rem_d = rem_q;
        q_d = q_q;
        den_d = den_q;
        cnt_d = cnt_q;
        busy_d = busy;
        done_d = 1'b0;
        quot_d = quot;
        trial = {rem_q[35:0], q_q[39]};
        if (start && !busy) begin
            rem_d = 37'h0;
            q_d = num;
            den_d = (den == 36'h0) ? 36'h1 : den;  // Guards an empty record
            cnt_d = RLM_DIV_STEPS;
            busy_d = 1'b1;
        end else if (busy) begin
            if (trial >= {1'b0, den_q}) begin
                rem_d = trial - {1'b0, den_q};
                q_d = {q_q[38:0], 1'b1};
            end else begin
                rem_d = trial;
                q_d = {q_q[38:0], 1'b0};
            end
            cnt_d = cnt_q - 6'h1;
            if (cnt_q == 6'h1) begin
                busy_d = 1'b0;
                done_d = 1'b1;
                quot_d = q_d;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rem_q <= 37'h0;
            q_q <= 40'h0;
            den_q <= 36'h1;
            cnt_q <= 6'h0;
            busy <= 1'b0;
            done <= 1'b0;
            quot <= 40'h0;
        end else begin
            rem_q <= rem_d;
            q_q <= q_d;
            den_q <= den_d;
            cnt_q <= cnt_d;
            busy <= busy_d;
            done <= done_d;
            quot <= quot_d;
        end
    end
endmodule // rlm_pct_div
`default_nettype wire

// [rtl/rlm_monitor.sv]
// Ribbon life monitor: cartridge record, density setting, end-of-life policy
`timescale 1ns/100ps
`default_nettype none
module rlm_monitor #(
    parameter logic [35:0] GRACE_CYC = rlm_pkg::RLM_GRACE_CYCLES,
    parameter logic [35:0] FLASH_CYC = rlm_pkg::RLM_FLASH_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Cartridge interface board
    input wire rlm_pkg::rlm_cart_t cart_in,
    output var rlm_pkg::rlm_wb_t cart_wb,
    output var rlm_pkg::rlm_info_t cart_info,
    // Print engine
    input wire logic dot_pulse,
    output var logic print_halt,
    output var logic keep_buffer,
    // Operator panel and configuration
    input wire rlm_pkg::rlm_keys_t keys,
    input wire logic platen_open,
    input wire logic halt_at_ink_end_policy,
    input wire logic alarm_enable,
    // Panel indications
    output var logic [6:0] life_pct,
    output var logic low_warn,
    output var logic lamp_flash,
    output var logic alarm,
    output var logic fault,
    output var rlm_pkg::rlm_msg_t msg,
    output var logic signed [4:0] density_step
);
    import rlm_pkg::*;

    // ********
    // End point from the type's count and the density offset
    // ********
    // Darker steps pull the end point in, lighter ones push it out
    function automatic logic [35:0] end_point(input logic [31:0] eol, input logic signed [4:0] step);
        logic [35:0] mag;
        logic [3:0] s;
        s = step[4] ? 4'(-step) : step[3:0];
        mag = 36'(eol >> RLM_STEP_SHIFT) * 36'(s);
        return step[4] ? 36'(eol) + mag : 36'(eol) - mag;
    endfunction

    // ********
    // Declarations
    // ********
    rlm_state_t st_q, st_d;
    logic [31:0] dots_q, dots_d, eol_q, eol_d, abs_q, abs_d;
    logic [11:0] wb_cnt_q, wb_cnt_d;
    logic fresh_q, fresh_d;
    rlm_info_t info_d;
    rlm_wb_t wb_d;
    logic signed [4:0] pend_q, pend_d, step_d;
    logic [6:0] life_d;
    logic low_d, flash_d, alarm_d, fault_d, halt_d, blink_q, blink_d;
    rlm_msg_t msg_d;
    logic [35:0] adj;
    logic counting, grace_load, grace_done, flash_run, flash_done;
    logic div_busy, div_done;
    logic [39:0] div_quot;

    // ********
    // Timers and divider
    // ********
    rlm_timer u_grace (
        .mclk(mclk),
        .rst_b(rst_b),
        .load(grace_load),
        .period(GRACE_CYC),
        .running(),
        .done(grace_done)
    );

    // Free-running blink: reloads whenever it falls idle
    rlm_timer u_flash (
        .mclk(mclk),
        .rst_b(rst_b),
        .load(!flash_run),
        .period(FLASH_CYC),
        .running(flash_run),
        .done(flash_done)
    );

    // Divider restarts as soon as it finishes, so a new end point shows within two passes
    rlm_pct_div u_div (
        .mclk(mclk),
        .rst_b(rst_b),
        .start(!div_busy), // R12
        .num(40'(dots_q) * 40'(RLM_FULL_PCT)), // R20
        .den(adj),
        .busy(div_busy),
        .done(div_done),
        .quot(div_quot)
    );

    assign adj = end_point(eol_q, density_step); // R11 R20
    assign counting = (st_q == ST_RUN) || (st_q == ST_GRACE);

    // ********
    // Density setting
    // ********
    // Arrows move a pending value; only Enter changes the live offset
    always_comb begin
        pend_d = pend_q;
        step_d = density_step;
        if (keys.left && pend_q < RLM_DARK_MAX) begin
            pend_d = pend_q + 5'sh01; // R10
        end else if (keys.right && pend_q > RLM_LIGHT_MIN) begin
            pend_d = pend_q - 5'sh01; // R10
        end
        if (keys.enter) begin
            step_d = pend_q; // R10 R9
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pend_q <= RLM_STEP_NORMAL;
            density_step <= RLM_STEP_NORMAL; // R9
        end else begin
            pend_q <= pend_d;
            density_step <= step_d;
        end
    end

    // ********
    // Cartridge record, dot count and life state
    // ********
    // A load from the board re-evaluates the cartridge in any state
    always_comb begin
        st_d = st_q;
        dots_d = dots_q;
        eol_d = eol_q;
        abs_d = abs_q;
        wb_cnt_d = wb_cnt_q;
        fresh_d = fresh_q;
        info_d = cart_info;
        wb_d = '0;
        wb_d.dots = dots_q;
        wb_d.ink_out = cart_wb.ink_out;
        grace_load = 1'b0;
        // Dots only count while the engine is allowed to print
        if (counting && dot_pulse) begin
            if (dots_q != 32'hffff_ffff) begin
                dots_d = dots_q + 32'h1; // R7
            end
            if (wb_cnt_q == RLM_WB_DOTS) begin
                wb_cnt_d = 12'h0;
                wb_d.strobe = 1'b1; // R7
                wb_d.dots = dots_d;
            end else begin
                wb_cnt_d = wb_cnt_q + 12'h1;
            end
        end
        unique case (st_q)
            ST_EMPTY, ST_OLD, ST_INK_OUT: begin
                if (st_q == ST_INK_OUT && keys.key_a) begin
                    st_d = ST_GRACE; // R14
                    grace_load = 1'b1;
                end
            end
            ST_GRACE: begin
                if (grace_done) begin
                    st_d = ST_INK_OUT; // R14
                end else if (keys.key_a) begin
                    grace_load = 1'b1;
                end
            end
            ST_RUN: begin
                if (halt_at_ink_end_policy && 36'(dots_q) >= adj) begin
                    st_d = ST_INK_OUT; // R3 R13
                    wb_d.strobe = 1'b1;
                    wb_d.ink_out = 1'b1;
                end else if (!halt_at_ink_end_policy && dots_q >= abs_q) begin
                    st_d = ST_WEAR; // R17
                    wb_d.strobe = 1'b1;
                    wb_d.ink_out = 1'b1; // R18
                end
            end
            ST_WEAR: begin
                if (platen_open) begin
                    st_d = ST_OLD; // R18
                end
            end
        endcase
        // A fresh cartridge takes effect once the platen is shut again
        if (fresh_q && !platen_open && st_q != ST_WEAR) begin
            st_d = ST_RUN; // R5
            fresh_d = 1'b0;
        end
        if (cart_in.load) begin
            info_d.length = cart_in.length; // R8
            info_d.colour = cart_in.colour;
            info_d.yield = cart_in.yield;
            info_d.is_new = cart_in.is_new;
            eol_d = cart_in.eol_dots; // R11
            abs_d = cart_in.abs_eol_dots;
            wb_cnt_d = 12'h0;
            wb_d.ink_out = cart_in.ink_out_mark;
            if (cart_in.is_new && cart_in.authorized) begin
                dots_d = 32'h0; // R5
                fresh_d = 1'b1;
            end else if (cart_in.ink_out_mark) begin
                st_d = ST_OLD; // R15 R19
                dots_d = cart_in.used_dots;
                fresh_d = 1'b0;
            end else begin
                st_d = ST_RUN; // R6 R19
                dots_d = cart_in.used_dots;
                fresh_d = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= ST_EMPTY; // R15
            dots_q <= 32'h0;
            eol_q <= 32'h0;
            abs_q <= 32'h0;
            wb_cnt_q <= 12'h0;
            fresh_q <= 1'b0;
            cart_info <= '0;
            cart_wb <= '0;
        end else begin
            st_q <= st_d;
            dots_q <= dots_d;
            eol_q <= eol_d;
            abs_q <= abs_d;
            wb_cnt_q <= wb_cnt_d;
            fresh_q <= fresh_d;
            cart_info <= info_d;
            cart_wb <= wb_d;
        end
    end

    // ********
    // Panel indications and engine control
    // ********
    // All indications are registered for clean outputs; all but life_pct decode the next state
    always_comb begin
        life_d = life_pct;
        blink_d = flash_done ? !blink_q : blink_q;
        if (fresh_q || (cart_in.load && cart_in.is_new && cart_in.authorized)) begin
            life_d = RLM_FULL_PCT; // R5
        end else if (st_q == ST_OLD || st_q == ST_EMPTY) begin
            life_d = 7'h0;
        end else if (div_done) begin
            // Past the end point the quotient exceeds 100; clamp to 0 life
            life_d = (div_quot >= 40'(RLM_FULL_PCT)) ? 7'h0 : RLM_FULL_PCT - div_quot[6:0]; // R1 R16
        end
        halt_d = (st_d == ST_EMPTY) || (st_d == ST_INK_OUT) || (st_d == ST_OLD) || (st_d == ST_WEAR); // R3 R17
        fault_d = (st_d == ST_INK_OUT) || (st_d == ST_OLD) || (st_d == ST_WEAR); // R13 R15
        // Run-past policy stays silent once life has reached 0
        low_d = ((st_d == ST_RUN) || (st_d == ST_GRACE)) && life_d <= RLM_LOW_PCT
            && (halt_at_ink_end_policy || life_d != 7'h0); // R2 R16
        alarm_d = alarm_enable && ((st_d == ST_INK_OUT) || (st_d == ST_WEAR)); // R21 R13 R17
        flash_d = blink_q && (fault_d || low_d); // R2 R13 R17
        unique case (st_d)
            ST_INK_OUT: msg_d = MSG_INK_OUT; // R13
            ST_GRACE: msg_d = MSG_GRACE;
            ST_OLD: msg_d = MSG_OLD; // R15
            ST_WEAR: msg_d = MSG_WEAR; // R17
            default: msg_d = low_d ? MSG_LOW : MSG_NONE; // R2
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            life_pct <= 7'h0;
            blink_q <= 1'b0;
            print_halt <= 1'b1;
            keep_buffer <= 1'b1;
            fault <= 1'b0;
            low_warn <= 1'b0;
            alarm <= 1'b0;
            lamp_flash <= 1'b0;
            msg <= MSG_NONE;
        end else begin
            life_pct <= life_d;
            blink_q <= blink_d;
            print_halt <= halt_d;
            keep_buffer <= halt_d; // R4
            fault <= fault_d;
            low_warn <= low_d;
            alarm <= alarm_d;
            lamp_flash <= flash_d;
            msg <= msg_d;
        end
    end
endmodule // rlm_monitor
`default_nettype wire

// [bench/rlm_monitor_sva.sv]
// Port-level assertion checker for the ribbon life monitor
`timescale 1ns/100ps
`default_nettype none
module rlm_monitor_sva
    import rlm_pkg::*;
#(
    parameter logic [35:0] FLASH_CYC = rlm_pkg::RLM_FLASH_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Inputs watched
    input wire rlm_pkg::rlm_cart_t cart_in,
    input wire rlm_pkg::rlm_keys_t keys,
    input wire logic platen_open,
    input wire logic alarm_enable,
    // Outputs watched
    input wire rlm_pkg::rlm_info_t cart_info,
    input wire logic print_halt,
    input wire logic keep_buffer,
    input wire logic [6:0] life_pct,
    input wire logic low_warn,
    input wire logic lamp_flash,
    input wire logic alarm,
    input wire logic fault,
    input wire rlm_pkg::rlm_msg_t msg,
    input wire logic signed [4:0] density_step
);
    // ********
    // Helper logic
    // ********
    logic alert;
    logic [7:0] dark_q, dark_d;
    // Cycles an alert has gone unlit; a stuck-dark lamp shows up here
    assign alert = low_warn || msg == MSG_INK_OUT || msg == MSG_WEAR;
    always_comb begin
        dark_d = (alert && !lamp_flash) ? dark_q + 8'h01 : 8'h00;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dark_q <= 8'h00;
        end else begin
            dark_q <= dark_d;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // ********
    // Properties
    // ********
    sequence s_fresh; cart_in.load && cart_in.is_new && cart_in.authorized && !cart_in.ink_out_mark; endsequence
    sequence s_clear; msg == MSG_INK_OUT && keys.key_a && !cart_in.load; endsequence
    property p_fresh; s_fresh |=> life_pct == RLM_FULL_PCT; endproperty
    property p_clear; s_clear |=> msg == MSG_GRACE ##[0:1] !print_halt; endproperty
    property p_old; cart_in.load && cart_in.ink_out_mark |=> fault && msg == MSG_OLD && print_halt; endproperty
    property p_info;
        cart_in.load |=> cart_info.yield == $past(cart_in.yield) && cart_info.length == $past(cart_in.length);
    endproperty
    property p_buf; keep_buffer == print_halt; endproperty
    property p_alarm; alarm |-> alarm_enable || $past(alarm_enable); endproperty
    property p_pct; life_pct <= RLM_FULL_PCT; endproperty
    property p_low; low_warn |-> life_pct <= RLM_LOW_PCT && !fault; endproperty
    property p_lamp; dark_q <= 2 * FLASH_CYC + 4; endproperty
    property p_fault; fault |-> print_halt; endproperty
    property p_den; !keys.enter |=> $stable(density_step); endproperty
    property p_range; density_step <= RLM_DARK_MAX && density_step >= RLM_LIGHT_MIN; endproperty
    property p_wear; msg == MSG_WEAR && !platen_open && !cart_in.load |=> msg == MSG_WEAR; endproperty
    a_fresh: assert property (p_fresh) else $error("no full life");
    a_clear: assert property (p_clear) else $error("no grace");
    a_old: assert property (p_old) else $error("ink out accepted");
    a_info: assert property (p_info) else $error("info not latched");
    a_buf: assert property (p_buf) else $error("buffer hold off");
    a_alarm: assert property (p_alarm) else $error("alarm while disabled");
    a_pct: assert property (p_pct) else $error("life above full");
    a_low: assert property (p_low) else $error("bad low warning");
    a_lamp: assert property (p_lamp) else $error("lamp dark");
    a_fault: assert property (p_fault) else $error("fault without halt");
    a_den: assert property (p_den) else $error("density moved");
    a_range: assert property (p_range) else $error("density out of span");
    a_wear: assert property (p_wear) else $error("wear left");
endmodule // rlm_monitor_sva

bind rlm_monitor rlm_monitor_sva #(.FLASH_CYC(FLASH_CYC)) i_sva (
    .mclk(mclk), .rst_b(rst_b), .cart_in(cart_in), .keys(keys), .platen_open(platen_open),
    .alarm_enable(alarm_enable), .cart_info(cart_info), .print_halt(print_halt), .keep_buffer(keep_buffer),
    .life_pct(life_pct), .low_warn(low_warn), .lamp_flash(lamp_flash), .alarm(alarm), .fault(fault),
    .msg(msg), .density_step(density_step)
);
`default_nettype wire

// [bench/rlm_cart_board.sv]
// Cartridge interface board model holding the ribbon record
`timescale 1ns/100ps
`default_nettype none
module rlm_cart_board
    import rlm_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Bench commands
    input wire logic insert,
    input wire logic fresh,
    input wire logic [31:0] preset,
    input wire logic [31:0] eol,
    input wire logic [31:0] abs_eol,
    // Monitor side
    input wire rlm_pkg::rlm_wb_t cart_wb,
    output var rlm_pkg::rlm_cart_t cart_in
);
    // ********
    // Record
    // ********
    logic [31:0] rec_dots = 32'h0;
    logic rec_mark = 1'b0;
    // Record survives printer reset, as a cartridge memory would
    always @(posedge mclk) begin
        if (cart_wb.strobe) begin
            rec_dots = cart_wb.dots;
            rec_mark = rec_mark | cart_wb.ink_out;
        end
        if (insert && (fresh || preset != 32'h0)) begin
            rec_dots = fresh ? 32'h0 : preset;
            rec_mark = 1'b0;
        end
        // Outside a read the lines toggle so stale fields cannot pass
        if (insert) begin
            cart_in <= {1'b1, fresh, 1'b1, rec_mark, rec_dots, eol, abs_eol, 16'h0a5c, 4'h3, 32'h000186a0};
        end else begin
            cart_in <= {1'b0, ~cart_in[150:0]};
        end
    end
endmodule // rlm_cart_board
`default_nettype wire

// [bench/rlm_monitor_tb.sv]
// Self-checking testbench for the ribbon life monitor
`timescale 1ns/100ps
`default_nettype none
module rlm_monitor_tb;
    import rlm_pkg::*;
    localparam rlm_keys_t K_L = 4'h8;
    localparam rlm_keys_t K_R = 4'h4;
    localparam rlm_keys_t K_E = 4'h2;
    localparam rlm_keys_t K_A = 4'h1;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    rlm_keys_t keys = '0;
    logic dot_pulse = 1'b0;
    logic platen_open = 1'b0;
    logic policy = 1'b1;
    logic alarm_enable = 1'b1;
    logic insert = 1'b0, fresh = 1'b0;
    logic [31:0] preset = 32'h0, eol = 32'h0, abs_eol = 32'h0;
    rlm_cart_t cart_in;
    rlm_wb_t cart_wb;
    rlm_info_t cart_info;
    rlm_msg_t msg;
    logic print_halt, keep_buffer, low_warn, lamp_flash, alarm, fault;
    logic [6:0] life_pct;
    logic signed [4:0] density_step;
    logic [32:0] wbq[$];
    int n_mismatch = 0;
    int samples_checked = 0;

    always #5 mclk = ~mclk;

    rlm_monitor #(.GRACE_CYC(36'd100), .FLASH_CYC(36'd4)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .cart_in(cart_in), .cart_wb(cart_wb), .cart_info(cart_info),
        .dot_pulse(dot_pulse), .print_halt(print_halt), .keep_buffer(keep_buffer), .keys(keys),
        .platen_open(platen_open), .halt_at_ink_end_policy(policy), .alarm_enable(alarm_enable),
        .life_pct(life_pct), .low_warn(low_warn), .lamp_flash(lamp_flash), .alarm(alarm),
        .fault(fault), .msg(msg), .density_step(density_step)
    );
    rlm_cart_board i_board (
        .mclk(mclk), .insert(insert), .fresh(fresh), .preset(preset), .eol(eol),
        .abs_eol(abs_eol), .cart_wb(cart_wb), .cart_in(cart_in)
    );

    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic look(input logic h, input logic f, input rlm_msg_t m);
        chk("print_halt", print_halt, h);
        chk("fault", fault, f);
        chk("msg", msg, m);
    endtask
    task automatic press(input rlm_keys_t k, input int n);
        repeat (n) begin
            @(posedge mclk);
            keys <= k;
            @(posedge mclk);
            keys <= '0;
        end
        cyc(90);
        #1;
    endtask
    // Divider may need two passes, so every step waits ninety
    task automatic load(input logic f, input logic [31:0] p, input logic [31:0] e);
        @(posedge mclk);
        insert <= 1'b1;
        fresh <= f;
        preset <= p;
        eol <= e;
        abs_eol <= e + 32'd10;
        @(posedge mclk);
        insert <= 1'b0;
        cyc(90);
        #1;
    endtask
    task automatic dots(input int n);
        repeat (n) begin
            @(posedge mclk);
            dot_pulse <= 1'b1;
            @(posedge mclk);
            dot_pulse <= 1'b0;
            cyc($urandom % 2);
        end
        cyc(90);
        #1;
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Writebacks are matched in order against the driver's notes
    always @(posedge mclk) begin
        if (rst_b && cart_wb.strobe === 1'b1) begin
            if (wbq.size() == 0) begin
                chk("cart_wb.strobe", 64'h0, 64'h1);
            end else begin
                chk("cart_wb", {cart_wb.ink_out, cart_wb.dots}, wbq.pop_front());
            end
        end
    end

    // ********
    // Scenarios
    // ********
    initial begin
        void'($urandom(92526));
        cyc(5);
        rst_b <= 1'b1;
        #1;
        look(1'b1, 1'b0, MSG_NONE);
        load(1'b1, 32'h0, 32'd100000);
        chk("life_pct", life_pct, RLM_FULL_PCT);
        chk("cart_info", cart_info, {16'h0a5c, 4'h3, 32'h000186a0, 1'b1});
        look(1'b0, 1'b0, MSG_NONE);
        wbq.push_back({1'b0, 32'd4096});
        dots(4096);
        chk("life_pct", life_pct, 7'd96);
        press(K_L, 8);
        chk("density_step", density_step, RLM_STEP_NORMAL);
        press(K_E, 1);
        chk("density_step", density_step, RLM_DARK_MAX);
        chk("life_pct", life_pct, 7'd95);
        press(K_R, 20);
        press(K_E, 1);
        chk("density_step", density_step, RLM_LIGHT_MIN);
        chk("life_pct", life_pct, 7'd97);
        // Used cartridge of another type keeps the lighter offset
        load(1'b0, 32'd990, 32'd1000);
        chk("life_pct", life_pct, 7'd25);
        press(K_L, 10);
        press(K_E, 1);
        chk("life_pct", life_pct, 7'd1);
        chk("low_warn", low_warn, 1'b1);
        wbq.push_back({1'b1, 32'd1000});
        dots(10);
        look(1'b1, 1'b1, MSG_INK_OUT);
        chk("keep_buffer", keep_buffer, 1'b1);
        chk("alarm", alarm, 1'b1);
        repeat (2) begin
            press(K_A, 1);
            chk("msg", msg, MSG_GRACE);
            cyc(20);
            #1;
            look(1'b1, 1'b1, MSG_INK_OUT);
        end
        @(posedge mclk);
        alarm_enable <= 1'b0;
        cyc(2);
        #1;
        chk("alarm", alarm, 1'b0);
        // Power cycle with the spent cartridge still fitted
        @(posedge mclk);
        alarm_enable <= 1'b1;
        rst_b <= 1'b0;
        cyc(5);
        rst_b <= 1'b1;
        load(1'b0, 32'h0, 32'd1000);
        look(1'b1, 1'b1, MSG_OLD);
        @(posedge mclk);
        policy <= 1'b0;
        load(1'b0, 32'd995, 32'd1000);
        dots(5);
        chk("life_pct", life_pct, 7'd0);
        chk("low_warn", low_warn, 1'b0);
        look(1'b0, 1'b0, MSG_NONE);
        wbq.push_back({1'b1, 32'd1010});
        dots(10);
        look(1'b1, 1'b1, MSG_WEAR);
        press(K_A, 1);
        look(1'b1, 1'b1, MSG_WEAR);
        @(posedge mclk);
        platen_open <= 1'b1;
        load(1'b1, 32'h0, 32'd1000);
        chk("msg", msg, MSG_OLD);
        @(posedge mclk);
        platen_open <= 1'b0;
        cyc(3);
        #1;
        look(1'b0, 1'b0, MSG_NONE);
        chk("life_pct", life_pct, RLM_FULL_PCT);
        tally_and_finish();
    end

    // Whole run needs about 12000 cycles
    initial begin
        cyc(60000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule // rlm_monitor_tb
`default_nettype wire
